// ### verilog/ccdrb_register_bank.sv
// Register bank of the CCD front end: serial capture, staging and grouped commit
`timescale 1ns/1ps
module ccdrb_register_bank
    import ccdrb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_load_strobe,
    input wire logic vertical_sync,
    input wire logic horizontal_sync,
    input wire logic sensor_gate_pulse,
    output ccdrb_afe_t afe,
    output ccdrb_load_t load_ctrl,
    output ccdrb_substrate_clock_t substrate,
    output logic [11:0] update_line,
    output logic update_blocked,
    output logic software_reset_pulse
);
    // Commit group of one address
    function automatic ccdrb_group_t reg_group(input logic [ADDR_W-1:0] a);
        ccdrb_group_t g;
        g = GRP_SYNC;
        if (a inside {OFS_OPERATION_MODE_LO, OFS_OPERATION_MODE_HI, OFS_CONTROL_MODE,
                      OFS_SOFTWARE_RESET, OFS_READBACK, OFS_FIELD_VALUE_RESET,
                      OFS_H1_BLANK_RETIME, OFS_H3_BLANK_RETIME, OFS_EXT_SYNC_ENABLE,
                      OFS_EXT_SYNC_POLARITY, OFS_SYNC_SUSPEND, OFS_TIMING_CORE_RESET,
                      OFS_FRAME_TRANSFER, OFS_SINGLE_CLAMP, OFS_OUTPUT_DELAY,
                      OFS_OSC_POWER_DOWN})
            g = GRP_LOAD;
        if (a >= OFS_HCLK_FIRST && a <= OFS_SYNC_POLARITY)
            g = GRP_LOAD;
        if (a >= OFS_SUBSTRATE_CLOCK_POLARITY && a <= OFS_SUBSTRATE_CLOCK_SUPPRESS)
            g = GRP_SENSE;
        return g;
    endfunction: reg_group

    // Lower address of a two-address register
    function automatic bit is_low_half(input logic [ADDR_W-1:0] a);
        return a inside {OFS_OPERATION_MODE_LO, OFS_VGA_GAIN_LO, OFS_BLACK_CLAMP_LO,
                         OFS_UPDATE_LINE_LO, OFS_SUBSTRATE_CLOCK_TOG0_LO, OFS_SUBSTRATE_CLOCK_TOG1_LO,
                         OFS_SUBSTRATE_CLOCK_TOG2_LO, OFS_SUBSTRATE_CLOCK_TOG3_LO};
    endfunction: is_low_half

    // Value after reset of one address
    function automatic logic [DATA_W-1:0] reset_value(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = RST_ZERO;
        case (a)
            OFS_OPERATION_MODE_LO: v = RST_OPERATION_MODE_LO;
            OFS_VGA_GAIN_LO: v = RST_VGA_GAIN_LO;
            OFS_VGA_GAIN_HI: v = RST_VGA_GAIN_HI;
            OFS_BLACK_CLAMP_HI: v = RST_BLACK_CLAMP_HI;
            OFS_FIELD_VALUE_RESET: v = RST_FIELD_VALUE_RESET;
            OFS_SINGLE_CLAMP: v = RST_SINGLE_CLAMP;
            OFS_OUTPUT_DELAY: v = RST_OUTPUT_DELAY;
            OFS_OSC_POWER_DOWN: v = RST_OSC_POWER_DOWN;
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction: reset_value

    ccdrb_word_t word;
    logic word_toggle;
    logic [4:0] pin_sync;
    logic [4:0] pin_last;
    logic [REG_COUNT-1:0][DATA_W-1:0] live_v;
    logic [DATA_W-1:0] low_buffer;
    logic load_commit;
    logic vsync_armed;
    logic [11:0] line_count;
    logic gate_armed;

    // Link-side receiver on the host's serial clock
    ccdrb_serial_rx u_rx (
        .serial_clock(serial_clock),
        .rst_b(rst_b),
        .serial_data(serial_data),
        .serial_load_strobe(serial_load_strobe),
        .word(word),
        .word_toggle(word_toggle)
    );

    // Strobe, word toggle and video syncs share one synchroniser
    ccdrb_sync2 #(
        .WIDTH(5),
        .RESET_VAL(SYNC_IDLE)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .din({serial_load_strobe, word_toggle, vertical_sync, horizontal_sync, sensor_gate_pulse}),
        .dout(pin_sync)
    );

    // Previous synchronised levels for edge detection
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            pin_last <= SYNC_IDLE;
        else
            pin_last <= pin_sync;
    end

    wire sync_pol = live_v[OFS_SYNC_POLARITY][0];
    wire soft_reset = live_v[OFS_SOFTWARE_RESET][0];
    wire prevent = live_v[OFS_PREVENT_UPDATE][0];

    // Edge decode; sync polarity selects which edge is the active one
    wire load_rise = pin_sync[4] && !pin_last[4];
    wire word_strobe = pin_sync[3] ^ pin_last[3];
    wire vsync_edge = (pin_sync[2] ^ pin_last[2]) && (pin_sync[2] == sync_pol);
    wire hsync_edge = (pin_sync[1] ^ pin_last[1]) && (pin_sync[1] == sync_pol);
    wire gate_rise = pin_sync[0] && !pin_last[0];
    wire in_range = word.addr < ADDR_W'(REG_COUNT);
    wire word_write = word_strobe && in_range;
    wire line_match = line_count == update_line;

    // Commit moments of the sync and sense groups
    wire sync_commit = hsync_edge && vsync_armed && !vsync_edge && line_match && !prevent;
    wire sense_commit = hsync_edge && gate_armed;

    // Low half parked until the upper address is written
    always_ff @(posedge clock)
    begin
        if (!rst_b || soft_reset)
            low_buffer <= RST_ZERO;
        else if (word_write && is_low_half(word.addr))
            low_buffer <= word.data;
    end

    // Strobe commit one cycle late so a final word lands first
    always_ff @(posedge clock)
    begin
        if (!rst_b || soft_reset)
            load_commit <= 1'b0;
        else
            load_commit <= load_rise;
    end

    // Line counter from the active vertical edge to the update line
    always_ff @(posedge clock)
    begin
        if (!rst_b || soft_reset)
        begin
            vsync_armed <= 1'b0;
            line_count <= 12'h000;
        end
        else if (vsync_edge)
        begin
            vsync_armed <= 1'b1;
            line_count <= 12'h000;
        end
        else if (hsync_edge && vsync_armed)
        begin
            if (line_match)
                vsync_armed <= 1'b0;
            else
                line_count <= 12'(line_count + 12'h001);
        end
    end

    // Sensor-gate line seen; next horizontal edge commits substrate group
    always_ff @(posedge clock)
    begin
        if (!rst_b || soft_reset)
            gate_armed <= 1'b0;
        else if (gate_rise)
            gate_armed <= 1'b1;
        else if (sense_commit)
            gate_armed <= 1'b0;
    end

    // One staged and one live word per address
    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++)
        begin : g_reg
            localparam logic [ADDR_W-1:0] ADDR = ADDR_W'(gi);
            localparam ccdrb_group_t GROUP = reg_group(ADDR);
            localparam bit LOW_HALF = is_low_half(ADDR);
            localparam logic [DATA_W-1:0] DEFAULT = reset_value(ADDR);
            logic [DATA_W-1:0] staged;
            logic [DATA_W-1:0] live;
            wire hit_self = word_write && (word.addr == ADDR);
            wire hit_upper = word_write && (word.addr == ADDR_W'(gi + 1));
            wire take = LOW_HALF ? hit_upper : hit_self;
            wire commit = (GROUP == GRP_LOAD) ? load_commit
                        : (GROUP == GRP_SENSE) ? sense_commit
                        : sync_commit;

            // Lone low write never reaches staging; lone high uses stale buffer
            always_ff @(posedge clock)
            begin
                if (!rst_b || soft_reset)
                    staged <= DEFAULT;
                else if (take)
                    staged <= LOW_HALF ? low_buffer : word.data;
            end

            // Pending data only reaches the logic at its group's moment
            always_ff @(posedge clock)
            begin
                if (!rst_b || soft_reset)
                    live <= DEFAULT;
                else if (commit)
                    live <= staged;
            end

            assign live_v[gi] = live;
        end
    endgenerate

    // Front-end fields, low bits from the lower address
    assign afe.afe_operation_mode = {live_v[OFS_OPERATION_MODE_HI][1:0],
                                     live_v[OFS_OPERATION_MODE_LO]};
    assign afe.vga_gain = {live_v[OFS_VGA_GAIN_HI][3:0], live_v[OFS_VGA_GAIN_LO]};
    assign afe.black_clamp_level = {live_v[OFS_BLACK_CLAMP_HI][1:0],
                                    live_v[OFS_BLACK_CLAMP_LO]};
    assign afe.afe_control_mode = live_v[OFS_CONTROL_MODE];
    assign afe.color_pixel_gain = {live_v[OFS_COLOR3_GAIN], live_v[OFS_COLOR2_GAIN],
                                   live_v[OFS_COLOR1_GAIN], live_v[OFS_COLOR0_GAIN]};

    // Strobe-committed controls
    assign load_ctrl.readback_enable = live_v[OFS_READBACK][0];
    assign load_ctrl.field_value_reset = live_v[OFS_FIELD_VALUE_RESET][0];
    assign load_ctrl.h1_blank_retime = live_v[OFS_H1_BLANK_RETIME][0];
    assign load_ctrl.h3_blank_retime = live_v[OFS_H3_BLANK_RETIME][0];
    assign load_ctrl.external_sync_enable = live_v[OFS_EXT_SYNC_ENABLE][0];
    assign load_ctrl.external_sync_polarity = live_v[OFS_EXT_SYNC_POLARITY][0];
    assign load_ctrl.suspend_during_sync = live_v[OFS_SYNC_SUSPEND][0];
    assign load_ctrl.timing_core_reset_n = live_v[OFS_TIMING_CORE_RESET][0];
    assign load_ctrl.frame_transfer_mode = live_v[OFS_FRAME_TRANSFER][0];
    assign load_ctrl.single_clamp = live_v[OFS_SINGLE_CLAMP][0];
    assign load_ctrl.output_data_delay = live_v[OFS_OUTPUT_DELAY][1:0];
    assign load_ctrl.oscillator_power_down = live_v[OFS_OSC_POWER_DOWN][0];
    assign load_ctrl.master_select = live_v[OFS_MASTER_SELECT][0];
    assign load_ctrl.sync_polarity = sync_pol;
    assign load_ctrl.hclk_timing = live_v[OFS_HCLK_LAST:OFS_HCLK_FIRST];

    // Substrate clock group, toggle positions as 12-bit pairs
    assign substrate.substrate_clock_start_polarity = live_v[OFS_SUBSTRATE_CLOCK_POLARITY][0];
    assign substrate.substrate_clock_toggle_positions = live_v[OFS_SUBSTRATE_CLOCK_COUNT-1:OFS_SUBSTRATE_CLOCK_TOG0_LO];
    assign substrate.substrate_clock_count = live_v[OFS_SUBSTRATE_CLOCK_COUNT];
    assign substrate.substrate_clock_suppress_count = live_v[OFS_SUBSTRATE_CLOCK_SUPPRESS];

    // Sync-update line and status views
    assign update_line = {live_v[OFS_UPDATE_LINE_HI], live_v[OFS_UPDATE_LINE_LO]};
    assign update_blocked = prevent;
    assign software_reset_pulse = soft_reset;
endmodule: ccdrb_register_bank

// ### verilog/ccdrb_pkg.sv
// Constants, carrier types and reset values of the CCD front-end register bank
// Operation
// - Wide registers span two adjacent addresses.
// - Other registers wait for the sync update point.
// - Mode, reset and sync controls commit on load strobe.
// - Clock edge and sample settings commit on load strobe.
// - Substrate clock settings commit after sensor-gate line.
// - Operation mode: 8 bits, defaults 10 and 00.
// - Gain: 10 bits, defaults 05 and 01.
// - Control mode: 6 bits at 06, reset 00.
// - Ten address bits then six data bits, LSB first.
// - Partial data word leaves register unchanged.
// - Further words go to incrementing addresses.
// - Load group at strobe rise; sync group on the update line after vertical sync; substrate group at the line after sensor gate.
package ccdrb_pkg;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 6;
    localparam int unsigned REG_COUNT = 77;
    localparam int unsigned HCLK_COUNT = 12;
    localparam logic [3:0] ADDR_LAST_BIT = 4'h9;
    localparam logic [3:0] DATA_LAST_BIT = 4'h5;
    // Synchroniser idle: strobe high, syncs high, toggle and gate low
    localparam logic [4:0] SYNC_IDLE = 5'h16;
    localparam logic [9:0] OFS_OPERATION_MODE_LO = 10'h000;
    localparam logic [9:0] OFS_OPERATION_MODE_HI = 10'h001;
    localparam logic [9:0] OFS_VGA_GAIN_LO = 10'h002;
    localparam logic [9:0] OFS_VGA_GAIN_HI = 10'h003;
    localparam logic [9:0] OFS_BLACK_CLAMP_LO = 10'h004;
    localparam logic [9:0] OFS_BLACK_CLAMP_HI = 10'h005;
    localparam logic [9:0] OFS_CONTROL_MODE = 10'h006;
    localparam logic [9:0] OFS_COLOR0_GAIN = 10'h007;
    localparam logic [9:0] OFS_COLOR1_GAIN = 10'h008;
    localparam logic [9:0] OFS_COLOR2_GAIN = 10'h009;
    localparam logic [9:0] OFS_COLOR3_GAIN = 10'h00A;
    localparam logic [9:0] OFS_SOFTWARE_RESET = 10'h017;
    localparam logic [9:0] OFS_UPDATE_LINE_LO = 10'h019;
    localparam logic [9:0] OFS_UPDATE_LINE_HI = 10'h01A;
    localparam logic [9:0] OFS_PREVENT_UPDATE = 10'h01B;
    localparam logic [9:0] OFS_READBACK = 10'h01C;
    localparam logic [9:0] OFS_FIELD_VALUE_RESET = 10'h021;
    localparam logic [9:0] OFS_H1_BLANK_RETIME = 10'h022;
    localparam logic [9:0] OFS_H3_BLANK_RETIME = 10'h023;
    localparam logic [9:0] OFS_EXT_SYNC_ENABLE = 10'h024;
    localparam logic [9:0] OFS_EXT_SYNC_POLARITY = 10'h025;
    localparam logic [9:0] OFS_SYNC_SUSPEND = 10'h026;
    localparam logic [9:0] OFS_TIMING_CORE_RESET = 10'h029;
    localparam logic [9:0] OFS_FRAME_TRANSFER = 10'h02A;
    localparam logic [9:0] OFS_SINGLE_CLAMP = 10'h031;
    localparam logic [9:0] OFS_OUTPUT_DELAY = 10'h032;
    localparam logic [9:0] OFS_OSC_POWER_DOWN = 10'h033;
    localparam logic [9:0] OFS_HCLK_FIRST = 10'h034;
    localparam logic [9:0] OFS_HCLK_LAST = 10'h03F;
    localparam logic [9:0] OFS_MASTER_SELECT = 10'h040;
    localparam logic [9:0] OFS_SYNC_POLARITY = 10'h041;
    localparam logic [9:0] OFS_SUBSTRATE_CLOCK_POLARITY = 10'h042;
    localparam logic [9:0] OFS_SUBSTRATE_CLOCK_TOG0_LO = 10'h043;
    localparam logic [9:0] OFS_SUBSTRATE_CLOCK_TOG1_LO = 10'h045;
    localparam logic [9:0] OFS_SUBSTRATE_CLOCK_TOG2_LO = 10'h047;
    localparam logic [9:0] OFS_SUBSTRATE_CLOCK_TOG3_LO = 10'h049;
    localparam logic [9:0] OFS_SUBSTRATE_CLOCK_COUNT = 10'h04B;
    localparam logic [9:0] OFS_SUBSTRATE_CLOCK_SUPPRESS = 10'h04C;
    localparam logic [5:0] RST_ZERO = 6'h00;
    localparam logic [5:0] RST_OPERATION_MODE_LO = 6'h10;
    localparam logic [5:0] RST_VGA_GAIN_LO = 6'h05;
    localparam logic [5:0] RST_VGA_GAIN_HI = 6'h01;
    localparam logic [5:0] RST_BLACK_CLAMP_HI = 6'h02;
    localparam logic [5:0] RST_FIELD_VALUE_RESET = 6'h01;
    localparam logic [5:0] RST_SINGLE_CLAMP = 6'h01;
    localparam logic [5:0] RST_OUTPUT_DELAY = 6'h02;
    localparam logic [5:0] RST_OSC_POWER_DOWN = 6'h01;
    typedef enum logic [1:0] {GRP_SYNC = 2'b00, GRP_LOAD = 2'b01, GRP_SENSE = 2'b10} ccdrb_group_t;
    typedef struct packed {
        logic [9:0] addr;
        logic [5:0] data;
    } ccdrb_word_t;
    typedef struct packed {
        logic [7:0] afe_operation_mode;
        logic [9:0] vga_gain;
        logic [7:0] black_clamp_level;
        logic [5:0] afe_control_mode;
        logic [3:0][5:0] color_pixel_gain;
    } ccdrb_afe_t;
    typedef struct packed {
        logic readback_enable;
        logic field_value_reset;
        logic h1_blank_retime;
        logic h3_blank_retime;
        logic external_sync_enable;
        logic external_sync_polarity;
        logic suspend_during_sync;
        logic timing_core_reset_n;
        logic frame_transfer_mode;
        logic single_clamp;
        logic [1:0] output_data_delay;
        logic oscillator_power_down;
        logic master_select;
        logic sync_polarity;
        logic [11:0][5:0] hclk_timing;
    } ccdrb_load_t;
    typedef struct packed {
        logic substrate_clock_start_polarity;
        logic [3:0][11:0] substrate_clock_toggle_positions;
        logic [5:0] substrate_clock_count;
        logic [5:0] substrate_clock_suppress_count;
    } ccdrb_substrate_clock_t;
endpackage: ccdrb_pkg

// ### verilog/ccdrb_sync2.sv
// Two-flop level synchroniser for pins entering the pixel clock domain
`timescale 1ns/1ps
module ccdrb_sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule: ccdrb_sync2

// ### verilog/ccdrb_serial_rx.sv
// Serial word receiver running on the host's link clock
`timescale 1ns/1ps
module ccdrb_serial_rx
    import ccdrb_pkg::*;
(
    input wire logic serial_clock,
    input wire logic rst_b,
    input wire logic serial_data,
    input wire logic serial_load_strobe,
    output ccdrb_word_t word,
    output logic word_toggle
);
    logic [3:0] bit_count;
    logic in_data;
    logic [ADDR_W-1:0] shifter;
    logic [ADDR_W-1:0] next_address;
    logic frame_idle;
    logic addr_done;
    logic data_done;

    // Strobe high ends a frame even though the link clock has stopped
    assign frame_idle = serial_load_strobe || !rst_b;
    assign addr_done = !in_data && (bit_count == ADDR_LAST_BIT);
    assign data_done = in_data && (bit_count == DATA_LAST_BIT);

    // Partial words are dropped when the frame ends
    always_ff @(posedge serial_clock or posedge frame_idle)
    begin
        if (frame_idle)
        begin
            bit_count <= 4'h0;
            in_data <= 1'b0;
            shifter <= '0;
            next_address <= '0;
        end
        else
        begin
            shifter <= {serial_data, shifter[ADDR_W-1:1]};
            bit_count <= (addr_done || data_done) ? 4'h0 : 4'(bit_count + 4'h1);
            if (addr_done)
            begin
                in_data <= 1'b1;
                next_address <= {serial_data, shifter[ADDR_W-1:1]};
            end
            else if (data_done)
                next_address <= ADDR_W'(next_address + 1'b1);
        end
    end

    // Word held stable for six link clocks while the toggle crosses
    always_ff @(posedge serial_clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            word <= '0;
            word_toggle <= 1'b0;
        end
        else if (data_done)
        begin
            word.addr <= next_address;
            word.data <= {serial_data, shifter[ADDR_W-1:ADDR_W-DATA_W+1]};
            word_toggle <= !word_toggle;
        end
    end
endmodule: ccdrb_serial_rx

// ### verif/ccdrb_register_bank_asserts.sv
// Checker for commit timing and reset values of the register bank
`timescale 1ns/1ps
module ccdrb_register_bank_asserts
    import ccdrb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic serial_load_strobe,
    input wire logic horizontal_sync,
    input wire logic sensor_gate_pulse,
    input wire ccdrb_afe_t afe,
    input wire ccdrb_load_t load_ctrl,
    input wire ccdrb_substrate_clock_t substrate,
    input wire logic [11:0] update_line,
    input wire logic update_blocked,
    input wire logic software_reset_pulse
);
    localparam logic [55:0] AFE_DEF = {8'h10, 10'h045, 8'h80, 6'h00, 24'h000000};
    logic sl_q;
    logic hs_q;
    logic sg_q;
    logic [3:0] sl_age;
    logic [3:0] hs_age;
    logic [7:0] sg_age;
    // Ages since pin edges; saturate so a stale edge never reopens a window
    always_ff @(posedge clock)
    begin
        sl_q <= rst_b ? serial_load_strobe : 1'b1;
        hs_q <= rst_b ? horizontal_sync : 1'b1;
        sg_q <= rst_b ? sensor_gate_pulse : 1'b0;
        sl_age <= !rst_b ? 4'hF : (serial_load_strobe && !sl_q) ? 4'h0 : sl_age + {3'h0, sl_age != 4'hF};
        hs_age <= !rst_b ? 4'hF : (!horizontal_sync && hs_q) ? 4'h0 : hs_age + {3'h0, hs_age != 4'hF};
        sg_age <= !rst_b ? 8'hFF : (sensor_gate_pulse && !sg_q) ? 8'h00 : sg_age + {7'h0, sg_age != 8'hFF};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_defaults_back;
        ##[1:2] (afe == AFE_DEF);
    endsequence
    property p_reset_afe;
        $rose(rst_b) |-> afe == AFE_DEF;
    endproperty
    property p_reset_load;
        $rose(rst_b) |-> load_ctrl.field_value_reset && load_ctrl.single_clamp && load_ctrl.oscillator_power_down
            && load_ctrl.output_data_delay == 2'h2 && substrate == '0 && update_line == 12'h000;
    endproperty
    property p_opmode_strobe;
        ($changed(afe.afe_operation_mode) || $changed(afe.afe_control_mode)) |-> sl_age <= 4'hC;
    endproperty
    property p_load_strobe;
        $changed(load_ctrl) |-> sl_age <= 4'hC;
    endproperty
    property p_gain_line;
        ($changed(afe.vga_gain) || $changed(afe.color_pixel_gain)) |-> hs_age <= 4'h8 || sl_age <= 4'hC;
    endproperty
    property p_substrate_clock_line;
        $changed(substrate) |-> (hs_age <= 4'h8 && sg_age != 8'hFF) || sl_age <= 4'hC;
    endproperty
    property p_update_ctrl_line;
        ($changed(update_line) || $changed(update_blocked)) |-> hs_age <= 4'h8 || sl_age <= 4'hC;
    endproperty
    property p_swreset;
        software_reset_pulse |-> s_defaults_back;
    endproperty
    a_reset_afe: assert property (p_reset_afe) else $error("afe not at defaults after reset");
    a_reset_load: assert property (p_reset_load) else $error("controls not at defaults after reset");
    a_opmode_strobe: assert property (p_opmode_strobe) else $error("mode changed away from strobe");
    a_load_strobe: assert property (p_load_strobe) else $error("strobe group changed away from strobe");
    a_gain_line: assert property (p_gain_line) else $error("gain changed away from line edge");
    a_substrate_clock_line: assert property (p_substrate_clock_line) else $error("substrate changed off gate line");
    a_update_ctrl_line: assert property (p_update_ctrl_line) else $error("update control changed early");
    a_swreset: assert property (p_swreset) else $error("software reset left values");
endmodule: ccdrb_register_bank_asserts

bind ccdrb_register_bank ccdrb_register_bank_asserts u_chk (.clock(clock), .rst_b(rst_b),
    .serial_load_strobe(serial_load_strobe), .horizontal_sync(horizontal_sync),
    .sensor_gate_pulse(sensor_gate_pulse), .afe(afe), .load_ctrl(load_ctrl), .substrate(substrate),
    .update_line(update_line), .update_blocked(update_blocked), .software_reset_pulse(software_reset_pulse));

// ### verif/ccdrb_host_model.sv
// Host model driving the three-wire serial port
`timescale 1ns/1ps
module ccdrb_host_model (
    output logic serial_clock,
    output logic serial_data,
    output logic serial_load_strobe
);
    // Link clock idles low and stands still between frames
    initial
    begin
        serial_clock = 1'b0;
        serial_data = 1'b1;
        serial_load_strobe = 1'b1;
    end
    // One frame: address then words at rising addresses, all LSB first
    task automatic send(input logic [9:0] addr, input logic [65:0] data, input int nbits);
        logic [75:0] bits;
        bits = {data, addr};
        serial_load_strobe = 1'b0;
        #40;
        for (int i = 0; i < 10 + nbits; i++)
        begin
            serial_data = bits[i];
            #32 serial_clock = 1'b1;
            #32 serial_clock = 1'b0;
        end
        // Released line flips so a stale bit never looks valid
        serial_data = ~serial_data;
        #60 serial_load_strobe = 1'b1;
        #200;
    endtask: send
endmodule: ccdrb_host_model

// ### verif/ccd_afe_register_update_bank_tb_top.sv
// Self-checking bench for the CCD front-end register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module ccd_afe_register_update_bank_tb_top;
    import ccdrb_pkg::*;
    localparam logic [55:0] AFE_DEF = {8'h10, 10'h045, 8'h80, 6'h00, 24'h000000};
    logic clock;
    logic rst_b;
    logic vertical_sync;
    logic horizontal_sync;
    logic sensor_gate_pulse;
    wire serial_clock;
    wire serial_data;
    wire serial_load_strobe;
    ccdrb_afe_t afe;
    ccdrb_load_t load_ctrl;
    ccdrb_substrate_clock_t substrate;
    logic [11:0] update_line;
    logic update_blocked;
    logic software_reset_pulse;
    int err_total;
    int comparisons;
    int sw_seen;
    // Soft reset pulses
    always @(negedge clock)
        if (software_reset_pulse === 1'b1) sw_seen++;
    ccdrb_host_model host (.serial_clock(serial_clock), .serial_data(serial_data),
        .serial_load_strobe(serial_load_strobe));
    ccdrb_register_bank DUT (.clock(clock), .rst_b(rst_b), .serial_clock(serial_clock),
        .serial_data(serial_data), .serial_load_strobe(serial_load_strobe), .vertical_sync(vertical_sync),
        .horizontal_sync(horizontal_sync), .sensor_gate_pulse(sensor_gate_pulse), .afe(afe),
        .load_ctrl(load_ctrl), .substrate(substrate), .update_line(update_line),
        .update_blocked(update_blocked), .software_reset_pulse(software_reset_pulse));
    // Pixel clock at 40 MHz
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic final_report;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask: final_report
    // Pulse on a sync pin: 0 vertical, 1 horizontal, 2 sensor gate (active high)
    task automatic pulse(input int sel);
        @(negedge clock);
        if (sel == 0) vertical_sync = 1'b0;
        if (sel == 1) horizontal_sync = 1'b0;
        if (sel == 2) sensor_gate_pulse = 1'b1;
        repeat (4) @(negedge clock);
        vertical_sync = 1'b1;
        horizontal_sync = 1'b1;
        sensor_gate_pulse = 1'b0;
        repeat (8) @(negedge clock);
    endtask: pulse
    task automatic frame_end;
        pulse(0);
        pulse(1);
    endtask: frame_end
    task automatic t_reset;
        `CHK("afe", AFE_DEF, afe)
        `CHK("defaults", 5'h1F, {load_ctrl.field_value_reset, load_ctrl.single_clamp,
            load_ctrl.output_data_delay == 2'h2, load_ctrl.oscillator_power_down,
            substrate == '0})
        `CHK("update", 13'h0000, {update_line, update_blocked})
    endtask: t_reset
    // Burst over the whole front-end map, strobe group first, rest on the line
    task automatic t_burst;
        host.send(10'h000, {6'h04, 6'h03, 6'h02, 6'h01, 6'h1C, 6'h01, 6'h15, 6'h0A, 6'h3F, 6'h03, 6'h2A}, 66);
        `CHK("op_mode", 8'hEA, afe.afe_operation_mode)
        `CHK("ctl_mode", 6'h1C, afe.afe_control_mode)
        `CHK("gain_held", 10'h045, afe.vga_gain)
        pulse(1);
        `CHK("gain_no_vsync", 10'h045, afe.vga_gain)
        frame_end();
        `CHK("gain", 10'h2BF, afe.vga_gain)
        `CHK("clamp", 8'h55, afe.black_clamp_level)
        `CHK("colors", 24'h103081, afe.color_pixel_gain)
    endtask: t_burst
    task automatic t_short_word;
        host.send(10'h006, 66'h05, 3);
        `CHK("ctl_partial", 6'h1C, afe.afe_control_mode)
    endtask: t_short_word
    task automatic t_lone_low;
        host.send(10'h002, 66'h11, 6);
        frame_end();
        `CHK("gain_lone_low", 10'h2BF, afe.vga_gain)
    endtask: t_lone_low
    task automatic t_load_group;
        host.send(10'h032, {6'h2A, 6'h00, 6'h01}, 18);
        host.send(10'h024, 66'h01, 6);
        `CHK("dout_delay", 2'h1, load_ctrl.output_data_delay)
        `CHK("osc_pd", 1'b0, load_ctrl.oscillator_power_down)
        `CHK("hclk0", 6'h2A, load_ctrl.hclk_timing[0])
        `CHK("ext_sync", 1'b1, load_ctrl.external_sync_enable)
    endtask: t_load_group
    // Substrate settings ignore strobe and field commit, wait for gate line
    task automatic t_substrate;
        host.send(10'h042, {6'h02, 6'h05, 6'h01}, 18);
        frame_end();
        `CHK("substrate_clock_held", 1'b0, substrate.substrate_clock_start_polarity)
        pulse(2);
        `CHK("substrate_clock_no_line", 12'h000, substrate.substrate_clock_toggle_positions[0])
        pulse(1);
        `CHK("substrate_clock_pol", 1'b1, substrate.substrate_clock_start_polarity)
        `CHK("substrate_clock_tog", 12'h085, substrate.substrate_clock_toggle_positions[0])
    endtask: t_substrate
    task automatic t_prevent;
        host.send(10'h01B, 66'h01, 6);
        frame_end();
        host.send(10'h002, {6'h0A, 6'h21}, 12);
        frame_end();
        `CHK("gain_blocked", 10'h2BF, afe.vga_gain)
    endtask: t_prevent
    task automatic t_soft_reset;
        host.send(10'h017, 66'h01, 6);
        repeat (4) @(negedge clock);
        `CHK("afe_swreset", AFE_DEF, afe)
        `CHK("osc_swreset", 1'b1, load_ctrl.oscillator_power_down)
        `CHK("sw_pulses", 1, sw_seen)
    endtask: t_soft_reset
    initial
    begin
        err_total = 0;
        comparisons = 0;
        rst_b = 1'b0;
        vertical_sync = 1'b1;
        horizontal_sync = 1'b1;
        sensor_gate_pulse = 1'b0;
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        t_reset();
        t_burst();
        t_short_word();
        t_lone_low();
        t_load_group();
        t_substrate();
        t_prevent();
        t_soft_reset();
        final_report();
    end
    // Hang guard
    initial
    begin
        #1ms;
        err_total++;
        $display("[ERR] watchdog expected done seen hang");
        final_report();
    end
endmodule: ccd_afe_register_update_bank_tb_top
